/* File: verilog/failsafe_pkg.sv */
package failsafe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and times, each in its own unit
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned WD_PERIOD_MS = 256;
  localparam int unsigned RST_PULSE_US = 1000;
  localparam int unsigned CLAMP_MS = 100;
  localparam int unsigned BUS_IDLE_MS = 8000;

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts derived from the times
  localparam int unsigned TIMER_W = 28;
  typedef logic [TIMER_W-1:0] tick_t;
  localparam tick_t WD_PERIOD_CYC = tick_t'(WD_PERIOD_MS * CLK_KHZ);
  localparam tick_t RST_PULSE_CYC = tick_t'(RST_PULSE_US * CLK_MHZ);
  localparam tick_t CLAMP_CYC = tick_t'(CLAMP_MS * CLK_KHZ);
  localparam tick_t BUS_IDLE_CYC = tick_t'(BUS_IDLE_MS * CLK_KHZ);

  ////////////////////////////////////////////////////////////////////////////
  // watchdog failure counting
  localparam logic [3:0] WD_FAIL_LIMIT = 4'h8;
  localparam logic [3:0] WD_SAFE_FIRST = 4'h1;
  localparam logic [3:0] WD_SAFE_SECOND = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog setup and misc setup field positions, reset values
  localparam int unsigned WD_HOLD_BIT = 0;
  localparam int unsigned WD_SECOND_BIT = 4;
  localparam int unsigned MISC_CODE_LSB = 0;
  localparam int unsigned MISC_CODE_MSB = 2;
  localparam logic WD_HOLD_RST = 1'b0;
  localparam logic WD_SECOND_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // safe behaviour codes
  localparam logic [2:0] SAFE_KEEP = 3'h7;
  localparam logic [2:0] SAFE_IDLE_CUT = 3'h6;
  localparam logic [2:0] SAFE_IGN_CUT = 3'h5;
  localparam logic [2:0] SAFE_BOTH_CUT = 3'h4;
  localparam logic [2:0] SAFE_CODE_RST = SAFE_KEEP;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } setup_write_t;

  typedef struct packed {
    logic vdd_below_high;
    logic vdd_below_low;
    logic batt_below_start;
    logic por;
    logic rst_pin_low;
    logic wake1;
    logic can_active;
    logic can_wake;
    logic lin_wake;
    logic [2:0] debug_resistor_pin;
  } pin_sense_t;

  typedef struct packed {
    logic wd_cause;
    logic vdd_cause;
    logic clamp_cause;
    logic monitoring;
  } safe_status_t;

endpackage

/* File: verilog/event_timer.sv */
`timescale 1ns/1ps
// counts cycles while run is high, holds at the limit, clears when run drops
module event_timer #(
  parameter int W = 28
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire logic [W-1:0] limit_in,
  output logic done_out
);

  logic [W-1:0] count;

  // saturating up-counter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      count <= '0;
    end else if (count != limit_in) begin
      count <= count + W'(1);
    end
  end

  // level while the limit has been reached
  assign done_out = run_in && (count == limit_in);

endmodule // event_timer

/* File: verilog/supply_failsafe_supervisor.sv */
`timescale 1ns/1ps
module supply_failsafe_supervisor #(
  parameter failsafe_pkg::tick_t WD_PERIOD_CYC = failsafe_pkg::WD_PERIOD_CYC,
  parameter failsafe_pkg::tick_t RST_PULSE_CYC = failsafe_pkg::RST_PULSE_CYC,
  parameter failsafe_pkg::tick_t CLAMP_CYC = failsafe_pkg::CLAMP_CYC,
  parameter failsafe_pkg::tick_t BUS_IDLE_CYC = failsafe_pkg::BUS_IDLE_CYC
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire failsafe_pkg::pin_sense_t pins_in,
  input wire failsafe_pkg::setup_write_t wd_setup_in,
  input wire failsafe_pkg::setup_write_t misc_setup_in,
  input wire logic uv_low_sel_in,
  input wire logic normal_entry_in,
  input wire logic wd_refresh_ok_in,
  input wire logic safe_release_in,
  input wire logic batt_flag_clear_in,
  input wire logic io1_wake_en_in,
  output logic vdd_en_out,
  output logic rst_n_out,
  output logic limp_home_n_out,
  output logic battery_fail_flag_out,
  output logic low_batt_hold_out,
  output logic [2:0] safe_mode_out,
  output failsafe_pkg::safe_status_t safe_status_out
);

  typedef enum logic [1:0] {st_reset, st_request, st_normal, st_safe_off} state_t;

  localparam int T_WD = 0;
  localparam int T_PULSE = 1;
  localparam int T_CLAMP = 2;
  localparam int T_UV = 3;
  localparam int T_IDLE = 4;
  localparam int NUM_T = 5;

  state_t state;
  failsafe_pkg::pin_sense_t pins_meta;
  failsafe_pkg::pin_sense_t pins_s;
  logic wake1_q;
  logic hold;
  logic second_pulse;
  logic [2:0] hw_code;
  logic [2:0] sw_code;
  logic sw_override;
  logic [2:0] eval_mode;
  logic [3:0] fail_cnt;
  logic [3:0] fail_inc;
  logic [3:0] fail_need;
  logic safe_active;
  logic recovered;
  logic mon_active;
  logic io1_lost;
  logic io1_wake_armed;
  logic pd_off;
  logic [NUM_T-1:0] t_run;
  logic [NUM_T-1:0] t_done;
  failsafe_pkg::tick_t t_limit [NUM_T];
  logic vdd_uv;
  logic wd_active;
  logic wd_done;
  logic go_normal;
  logic wd_trig;
  logic uv_trig;
  logic clamp_trig;
  logic any_trig;
  logic recover_now;
  logic mon_start;
  logic cut_now;
  logic wake_now;

  // decides the supply cut from the monitored events
  function automatic logic cut_decision(input logic [2:0] mode, input logic idle,
                                        input logic ign);
    logic cut;
    cut = 1'b0;
    if (mode == failsafe_pkg::SAFE_IDLE_CUT) begin
      cut = idle;
    end else if (mode == failsafe_pkg::SAFE_IGN_CUT) begin
      cut = ign;
    end else if (mode == failsafe_pkg::SAFE_BOTH_CUT) begin
      cut = idle && ign;
    end
    return cut;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two stages
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pins_meta <= '0;
      pins_s <= '0;
      wake1_q <= 1'b0;
    end else begin
      pins_meta <= pins_in;
      pins_s <= pins_meta;
      wake1_q <= pins_s.wake1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timers: watchdog period, reset pulse, clamp, undervoltage, bus idle
  assign t_limit[T_WD] = WD_PERIOD_CYC;
  assign t_limit[T_PULSE] = RST_PULSE_CYC;
  assign t_limit[T_CLAMP] = CLAMP_CYC;
  assign t_limit[T_UV] = CLAMP_CYC;
  assign t_limit[T_IDLE] = BUS_IDLE_CYC;

  generate
    for (genvar i = 0; i < NUM_T; i++) begin : g_timer
      event_timer #(
        .W(failsafe_pkg::TIMER_W)
      ) u_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(t_run[i]),
        .limit_in(t_limit[i]),
        .done_out(t_done[i])
      );
    end
  endgenerate

  // timer run conditions
  assign t_run[T_WD] = wd_active && !wd_refresh_ok_in;
  assign t_run[T_PULSE] = (state == st_reset) && !vdd_uv;
  assign t_run[T_CLAMP] = pins_s.rst_pin_low && rst_n_out;
  assign t_run[T_UV] = vdd_uv;
  assign t_run[T_IDLE] = mon_active && !pins_s.can_active;

  ////////////////////////////////////////////////////////////////////////////
  // event decode
  assign vdd_uv = uv_low_sel_in ? pins_s.vdd_below_low : pins_s.vdd_below_high;
  assign wd_active = (state == st_request) || (state == st_normal);
  assign wd_done = t_done[T_WD];
  assign go_normal = (state == st_request) && normal_entry_in && !vdd_uv && !wd_done;
  assign fail_inc = fail_cnt + 4'h1;
  assign fail_need = second_pulse ? failsafe_pkg::WD_SAFE_SECOND
                                  : failsafe_pkg::WD_SAFE_FIRST;
  assign wd_trig = wd_done && (fail_inc >= fail_need);
  assign uv_trig = vdd_uv && wd_active;
  assign clamp_trig = t_done[T_CLAMP];
  assign any_trig = wd_trig || uv_trig || clamp_trig;
  // needs pins released and a good refresh
  assign recover_now = wd_refresh_ok_in && !vdd_uv && !pins_s.rst_pin_low;
  assign mon_start = (wd_done && (fail_inc == failsafe_pkg::WD_FAIL_LIMIT))
                     || t_done[T_UV] || clamp_trig;
  assign cut_now = mon_active && (state != st_safe_off)
                   && cut_decision(eval_mode, t_done[T_IDLE], io1_lost);
  assign wake_now = (state == st_safe_off)
                    && (pins_s.can_wake || pins_s.lin_wake
                        || (pins_s.wake1 && io1_wake_armed));

  ////////////////////////////////////////////////////////////////////////////
  // operating mode
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= st_reset;
    end else if (cut_now) begin
      state <= st_safe_off;
    end else begin
      case (state)
        st_reset: begin
          if (t_done[T_PULSE]) begin
            state <= st_request;
          end
        end
        st_request: begin
          if (vdd_uv || wd_done) begin
            state <= st_reset;
          end else if (normal_entry_in) begin
            state <= st_normal;
          end
        end
        st_normal: begin
          if (vdd_uv || wd_done) begin
            state <= st_reset;
          end
        end
        st_safe_off: begin
          if (wake_now) begin
            state <= st_reset;
          end
        end
        default: begin
          state <= st_reset;
        end
      endcase
    end
  end

  // reset output low in reset and while the supply is cut
  assign rst_n_out = !((state == st_reset) || (state == st_safe_off));

  ////////////////////////////////////////////////////////////////////////////
  // watchdog setup bits, written only by software
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hold <= failsafe_pkg::WD_HOLD_RST;
      second_pulse <= failsafe_pkg::WD_SECOND_RST;
    end else if (wd_setup_in.wr) begin
      hold <= wd_setup_in.data[failsafe_pkg::WD_HOLD_BIT];
      second_pulse <= wd_setup_in.data[failsafe_pkg::WD_SECOND_BIT];
    end
  end

  assign low_batt_hold_out = hold;

  ////////////////////////////////////////////////////////////////////////////
  // safe behaviour selection: resistor sample and software override
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hw_code <= failsafe_pkg::SAFE_CODE_RST;
    end else if (go_normal) begin
      hw_code <= pins_s.debug_resistor_pin;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      sw_code <= failsafe_pkg::SAFE_CODE_RST;
      sw_override <= 1'b0;
    end else if (misc_setup_in.wr) begin
      sw_code <= misc_setup_in.data[failsafe_pkg::MISC_CODE_MSB:failsafe_pkg::MISC_CODE_LSB];
      sw_override <= 1'b1;
    end
  end

  assign safe_mode_out = sw_override ? sw_code : hw_code;

  ////////////////////////////////////////////////////////////////////////////
  // consecutive watchdog failure count, cleared by a good refresh
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fail_cnt <= 4'h0;
    end else if (wd_refresh_ok_in) begin
      fail_cnt <= 4'h0;
    end else if (wd_done && (fail_cnt != failsafe_pkg::WD_FAIL_LIMIT)) begin
      fail_cnt <= fail_inc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // safe state flag and causes; a new failure beats the release
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      safe_active <= 1'b0;
    end else if (any_trig) begin
      safe_active <= 1'b1;
    end else if (safe_release_in && recovered) begin
      safe_active <= 1'b0;
    end
  end

  assign limp_home_n_out = !safe_active;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      recovered <= 1'b1;
    end else if (any_trig) begin
      recovered <= 1'b0;
    end else if (recover_now) begin
      recovered <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      safe_status_out <= '0;
    end else begin
      safe_status_out.monitoring <= mon_active;
      if (wd_trig) begin
        safe_status_out.wd_cause <= 1'b1;
      end else if (safe_release_in && recovered) begin
        safe_status_out.wd_cause <= 1'b0;
      end
      if (uv_trig) begin
        safe_status_out.vdd_cause <= 1'b1;
      end else if (safe_release_in && recovered) begin
        safe_status_out.vdd_cause <= 1'b0;
      end
      if (clamp_trig) begin
        safe_status_out.clamp_cause <= 1'b1;
      end else if (safe_release_in && recovered) begin
        safe_status_out.clamp_cause <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external event monitoring, mode frozen at evaluation
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mon_active <= 1'b0;
      eval_mode <= failsafe_pkg::SAFE_CODE_RST;
    end else if (mon_start) begin
      mon_active <= 1'b1;
      eval_mode <= safe_mode_out;
    end else if (recover_now || wake_now) begin
      mon_active <= 1'b0;
    end
  end

  // ignition loss seen as a falling edge on wake1
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !mon_active) begin
      io1_lost <= 1'b0;
    end else if (wake1_q && !pins_s.wake1) begin
      io1_lost <= 1'b1;
    end else if (pins_s.wake1) begin
      io1_lost <= 1'b0;
    end
  end

  // wake1 wake-up enable captured when the supply is cut
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      io1_wake_armed <= 1'b0;
    end else if (cut_now) begin
      io1_wake_armed <= io1_wake_en_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // battery ramp-down handling and supply enable
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pd_off <= 1'b0;
    end else if ((state == st_reset) && vdd_uv && !hold && pins_s.batt_below_start) begin
      pd_off <= 1'b1;
    end else if (hold && pins_s.por) begin
      pd_off <= 1'b1;
    end else if (!pins_s.batt_below_start && !pins_s.por) begin
      pd_off <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      battery_fail_flag_out <= 1'b0;
    end else if (pins_s.por) begin
      battery_fail_flag_out <= 1'b1;
    end else if (batt_flag_clear_in) begin
      battery_fail_flag_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      vdd_en_out <= 1'b0;
    end else begin
      vdd_en_out <= !(pd_off || (state == st_safe_off));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_hold_write;
    !wd_setup_in.wr |=> (hold == $past(hold));
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold bit changed without write");

  property p_uv_select;
    (state == st_normal) && uv_low_sel_in && pins_s.vdd_below_low && !cut_now
      |=> (state == st_reset);
  endproperty
  a_uv_select: assert property (p_uv_select) else $error("low threshold did not reset");

  property p_supply_drop;
    (state == st_reset) && vdd_uv && !hold && pins_s.batt_below_start |=> ##1 !vdd_en_out;
  endproperty
  a_supply_drop: assert property (p_supply_drop) else $error("supply kept on low battery");

  property p_hold_keep;
    hold && pins_s.por |=> battery_fail_flag_out ##1 !vdd_en_out;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("por did not drop supply");

  property p_sample;
    go_normal |=> (hw_code == $past(pins_s.debug_resistor_pin));
  endproperty
  a_sample: assert property (p_sample) else $error("resistor code not sampled");

  property p_override;
    misc_setup_in.wr |=> (safe_mode_out == $past(misc_setup_in.data[2:0]));
  endproperty
  a_override: assert property (p_override) else $error("override not applied");

  property p_keep_supply;
    mon_active && (eval_mode == failsafe_pkg::SAFE_KEEP) && (state != st_safe_off)
      |=> (state != st_safe_off);
  endproperty
  a_keep_supply: assert property (p_keep_supply) else $error("keep mode cut supply");

  property p_idle_cut;
    mon_active && (eval_mode == failsafe_pkg::SAFE_IDLE_CUT) && t_done[T_IDLE]
      && (state != st_safe_off) |=> (state == st_safe_off) ##1 !vdd_en_out;
  endproperty
  a_idle_cut: assert property (p_idle_cut) else $error("idle timeout did not cut");

  property p_wd_reset;
    wd_done |=> !rst_n_out [*2];
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("no reset pulse on expiry");

  property p_limp_uv;
    uv_trig |=> !rst_n_out && !limp_home_n_out;
  endproperty
  a_limp_uv: assert property (p_limp_uv) else $error("limp and reset not together");

  property p_clamp;
    t_done[T_CLAMP] |=> !limp_home_n_out;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp did not enter safe");

  property p_wake;
    (state == st_safe_off) && pins_s.can_wake && !cut_now |=> (state == st_reset);
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not enter reset");

  property p_release;
    safe_active && !safe_release_in |=> !limp_home_n_out;
  endproperty
  a_release: assert property (p_release) else $error("limp released without command");

endmodule // supply_failsafe_supervisor

/* File: tb/mcu_model.sv */
`timescale 1ns/1ps
// mcu side: periodic watchdog refresh and safe release commands
module mcu_model (
  input wire logic clk_in,
  input wire logic refresh_en_in,
  input wire logic release_req_in,
  output logic refresh_ok_out,
  output logic release_out
);
  logic [5:0] gap;
  initial begin
    gap = 6'h00;
    refresh_ok_out = 1'b0;
    release_out = 1'b0;
  end
  // one inverted-code refresh every 64 cycles, release forwarded as one command
  // updated on the edge itself, so the bench's request of the last cycle is seen
  always @(posedge clk_in) begin
    gap <= gap + 6'h01;
    refresh_ok_out <= refresh_en_in && (gap == 6'h3F);
    release_out <= release_req_in;
  end
endmodule // mcu_model

/* File: tb/supply_failsafe_supervisor_test.sv */
`timescale 1ns/1ps
module supply_failsafe_supervisor_test;
  typedef struct packed {
    logic [7:0] wd;
    logic [7:0] misc;
    logic hold;
    logic [2:0] mode;
  } row_t;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  failsafe_pkg::pin_sense_t pins = '0;
  failsafe_pkg::setup_write_t wd_wr = '0;
  failsafe_pkg::setup_write_t misc_wr = '0;
  logic uv_sel = 1'b0, normal_req = 1'b0, rel_req = 1'b0, ref_en = 1'b1, flag_clr = 1'b0;
  logic io1_en = 1'b0;
  logic refresh_ok, release_cmd, vdd_en, rst_n, limp_n, bat_flag, hold;
  logic [2:0] mode;
  failsafe_pkg::safe_status_t status;
  int error_cnt = 0, comparisons = 0, n;
  row_t rows [4] = '{'{8'h01, 8'h07, 1'b1, 3'h7}, '{8'h00, 8'h06, 1'b0, 3'h6},
                     '{8'h11, 8'h05, 1'b1, 3'h5}, '{8'h10, 8'h04, 1'b0, 3'h4}};

  // shortened counts: period 200, pulse 10, clamp 50, idle 100
  supply_failsafe_supervisor #(.WD_PERIOD_CYC(28'h000_00C8), .RST_PULSE_CYC(28'h000_000A),
    .CLAMP_CYC(28'h000_0032), .BUS_IDLE_CYC(28'h000_0064)) u_supply_failsafe_supervisor (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .pins_in(pins), .wd_setup_in(wd_wr),
    .misc_setup_in(misc_wr), .uv_low_sel_in(uv_sel), .normal_entry_in(normal_req),
    .wd_refresh_ok_in(refresh_ok), .safe_release_in(release_cmd),
    .batt_flag_clear_in(flag_clr), .io1_wake_en_in(io1_en), .vdd_en_out(vdd_en),
    .rst_n_out(rst_n), .limp_home_n_out(limp_n), .battery_fail_flag_out(bat_flag),
    .low_batt_hold_out(hold), .safe_mode_out(mode), .safe_status_out(status));
  mcu_model u_mcu_model (.clk_in(clk_in), .refresh_en_in(ref_en), .release_req_in(rel_req),
    .refresh_ok_out(refresh_ok), .release_out(release_cmd));

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_in);
      #2;
    end
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return rst_n;
      1: return limp_n;
      2: return vdd_en;
      3: return status.monitoring;
      default: return bat_flag;
    endcase
  endfunction

  // bounded wait, n holds the cycles spent
  task automatic wait_for(input int sel, input logic val, input int bound);
    n = 0;
    while (pick(sel) !== val) begin
      if (n == bound) begin
        error_cnt++;
        $display("mismatch wait %0d expected %b seen %b", sel, val, pick(sel));
        results();
      end
      tick(1);
      n++;
    end
  endtask

  task automatic wr_wd(input logic [7:0] d);
    wd_wr = '{wr: 1'b1, data: d};
    tick(1);
    wd_wr.wr = 1'b0;
  endtask

  task automatic wr_misc(input logic [7:0] d);
    misc_wr = '{wr: 1'b1, data: d};
    tick(1);
    misc_wr.wr = 1'b0;
  endtask

  // good refreshes, then release command
  task automatic recover();
    ref_en = 1'b1;
    tick(150);
    rel_req = 1'b1;
    tick(1);
    rel_req = 1'b0;
    tick(4);
    check("limp_release", limp_n, 1'b1);
  endtask

  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pins.wake1 = 1'b1;
    pins.debug_resistor_pin = 3'h6;
    tick(11);
    check("rst_in_reset", rst_n, 1'b0);
    check("limp_in_reset", limp_n, 1'b1);
    check("hold_reset", hold, 1'b0);
    check("mode_reset", mode, 3'h7);
    tick(1);
    sys_rst_in = 1'b0;
    wait_for(0, 1'b1, 100);
    normal_req = 1'b1;
    tick(1);
    normal_req = 1'b0;
    tick(2);
    check("mode_resistor", mode, 3'h6);
    $display("test reset done");
    foreach (rows[i]) begin
      wr_wd(rows[i].wd);
      wr_misc(rows[i].misc);
      tick(1);
      check("hold_bit", hold, rows[i].hold);
      check("mode_override", mode, rows[i].mode);
    end
    $display("test setup table done");
    uv_sel = 1'b1;
    pins.vdd_below_high = 1'b1;
    tick(20);
    check("uv_low_sel", rst_n, 1'b1);
    pins.vdd_below_low = 1'b1;
    wait_for(0, 1'b0, 10);
    check("uv_low_trip", limp_n, 1'b0);
    pins.vdd_below_high = 1'b0;
    pins.vdd_below_low = 1'b0;
    uv_sel = 1'b0;
    wait_for(0, 1'b1, 100);
    recover();
    $display("test threshold done");
    // second-pulse entry, keep-supply mode
    wr_misc(8'h07);
    wr_wd(8'h10);
    ref_en = 1'b0;
    wait_for(0, 1'b0, 300);
    check("limp_first_pulse", limp_n, 1'b1);
    wait_for(0, 1'b1, 50);
    check("pulse_len", 8'(n), 8'h0B);
    wait_for(0, 1'b0, 300);
    check("limp_second_pulse", limp_n, 1'b0);
    check("vdd_keep", vdd_en, 1'b1);
    rel_req = 1'b1;
    tick(1);
    rel_req = 1'b0;
    tick(4);
    check("limp_unrecovered", limp_n, 1'b0);
    recover();
    $display("test watchdog done");
    // first-pulse entry, ignition cut after eight failures
    wr_wd(8'h00);
    wr_misc(8'h05);
    ref_en = 1'b0;
    wait_for(0, 1'b0, 300);
    check("limp_first", limp_n, 1'b0);
    wait_for(3, 1'b1, 2500);
    check("vdd_before_cut", vdd_en, 1'b1);
    pins.wake1 = 1'b0;
    wait_for(2, 1'b0, 10);
    check("vdd_ign_cut", vdd_en, 1'b0);
    pins.wake1 = 1'b1;
    tick(6);
    check("wake1_disabled", vdd_en, 1'b0);
    pins.can_wake = 1'b1;
    tick(1);
    pins.can_wake = 1'b0;
    wait_for(2, 1'b1, 10);
    check("wake_reset", rst_n, 1'b0);
    check("limp_after_wake", limp_n, 1'b0);
    wait_for(0, 1'b1, 100);
    recover();
    $display("test ignition done");
    // clamp entry, idle cut restarted by traffic, wake by enabled wake1
    wr_misc(8'h06);
    ref_en = 1'b0;
    io1_en = 1'b1;
    pins.wake1 = 1'b0;
    pins.rst_pin_low = 1'b1;
    tick(40);
    check("limp_clamp_early", limp_n, 1'b1);
    wait_for(1, 1'b0, 20);
    pins.rst_pin_low = 1'b0;
    tick(60);
    pins.can_active = 1'b1;
    tick(1);
    pins.can_active = 1'b0;
    tick(70);
    check("vdd_idle_restart", vdd_en, 1'b1);
    wait_for(2, 1'b0, 60);
    tick(6);
    check("vdd_idle_cut", vdd_en, 1'b0);
    pins.wake1 = 1'b1;
    wait_for(2, 1'b1, 10);
    check("wake1_reset", rst_n, 1'b0);
    io1_en = 1'b0;
    wait_for(0, 1'b1, 100);
    recover();
    $display("test clamp done");
    // undervoltage held into monitoring, combined cut needs idle and wake1 low
    wr_misc(8'h04);
    ref_en = 1'b0;
    pins.vdd_below_high = 1'b1;
    wait_for(3, 1'b1, 80);
    pins.vdd_below_high = 1'b0;
    pins.wake1 = 1'b0;
    tick(20);
    check("vdd_ign_only", vdd_en, 1'b1);
    wait_for(2, 1'b0, 120);
    pins.can_wake = 1'b1;
    tick(1);
    pins.can_wake = 1'b0;
    pins.wake1 = 1'b1;
    wait_for(0, 1'b1, 100);
    recover();
    $display("test combined done");
    pins.vdd_below_high = 1'b1;
    wait_for(0, 1'b0, 10);
    check("limp_with_rst", limp_n, 1'b0);
    pins.batt_below_start = 1'b1;
    wait_for(2, 1'b0, 10);
    check("vdd_low_batt", vdd_en, 1'b0);
    pins.batt_below_start = 1'b0;
    pins.vdd_below_high = 1'b0;
    wait_for(0, 1'b1, 100);
    recover();
    $display("test undervoltage done");
    wr_misc(8'h07);
    wr_wd(8'h01);
    pins.vdd_below_high = 1'b1;
    pins.batt_below_start = 1'b1;
    wait_for(3, 1'b1, 80);
    check("vdd_hold", vdd_en, 1'b1);
    pins.por = 1'b1;
    wait_for(4, 1'b1, 10);
    wait_for(2, 1'b0, 5);
    pins = '0;
    pins.wake1 = 1'b1;
    tick(3);
    flag_clr = 1'b1;
    tick(1);
    flag_clr = 1'b0;
    tick(2);
    check("flag_clear", bat_flag, 1'b0);
    $display("test hold done");
    results();
  end
endmodule // supply_failsafe_supervisor_test
